/* File: verilog/aes_defines.svh */
`ifndef AES_DEFINES_SVH
`define AES_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define AES_OFS_CORE_CFG 3'h0
`define AES_OFS_DP_CFG 3'h1
`define AES_OFS_KEY_IN 3'h2
`define AES_OFS_BLOCK_IN 3'h3
`define AES_OFS_XOR_IN 3'h4
`define AES_OFS_RESULT 3'h5

// ----------------------------------------
// core config fields
// ----------------------------------------
`define AES_CFG_KSIZE_LSB 0
`define AES_CFG_KSIZE_MSB 1
`define AES_CFG_ENC_BIT 2
`define AES_CFG_EN_BIT 3
`define AES_CFG_DMA_BIT 4
`define AES_CFG_DONE_BIT 5
`define AES_KSIZE_128 2'h0
`define AES_KSIZE_192 2'h1
`define AES_KSIZE_256 2'h2

// ----------------------------------------
// data path config fields
// ----------------------------------------
`define AES_DP_IN_XOR_BIT 0
`define AES_DP_OSEL_LSB 1
`define AES_DP_OSEL_MSB 2
`define AES_OSEL_DATA 2'h0
`define AES_OSEL_DATA_XOR 2'h1
`define AES_OSEL_KEY 2'h2
`define AES_DP_RESET 3'h0

// ----------------------------------------
// sizes and timing
// ----------------------------------------
`define AES_BLOCK_BYTES 6'h10
`define AES_KLEN_128 6'h10
`define AES_KLEN_192 6'h18
`define AES_KLEN_256 6'h20
`define AES_KINV_MASK 128'h63636363636363636363636363636363
`define AES_CLK_NS 5
`define AES_CORE_NS 100
`define AES_CORE_CYC ((`AES_CORE_NS + `AES_CLK_NS - 1) / `AES_CLK_NS)

`endif

/* File: verilog/aes_pkg.sv */
package aes_pkg;
	typedef enum logic [2:0] {
		ST_OFF,
		ST_LOAD,
		ST_KEYX,
		ST_BUSY,
		ST_OUT
	} aes_state_t;

	typedef struct packed {
		logic valid;
		logic [2:0] addr;
	} aes_dma_req_t;
endpackage

/* File: verilog/aes_block_cipher.sv */
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "aes_defines.svh"

module aes_block_cipher #(
	parameter int CORE_CYCLES = `AES_CORE_CYC
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic [2:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	output aes_pkg::aes_dma_req_t dma_req_o
);
	import aes_pkg::*;
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (sys_rst_i);

	// ----------------------------------------
	// state
	// ----------------------------------------
	aes_state_t st_q;
	logic [1:0] ksize_q;
	logic enc_q, en_q, dma_q, done_q;
	logic [2:0] dcfg_q;
	logic [7:0] blk_q, xor_q, rdata_q;
	logic [127:0] data_q, res_q;
	logic [255:0] key_q;
	logic [5:0] idx_q;
	logic [1:0] ph_q;
	logic [15:0] cnt_q;
	aes_dma_req_t dreq_q;

	// ----------------------------------------
	// access decode
	// ----------------------------------------
	logic wr_cfg, wr_dcfg, wr_key, wr_blk, wr_xor, rd_res;
	assign wr_cfg = reg_wr_i && reg_addr_i == `AES_OFS_CORE_CFG;
	assign wr_dcfg = reg_wr_i && reg_addr_i == `AES_OFS_DP_CFG;
	assign wr_key = reg_wr_i && reg_addr_i == `AES_OFS_KEY_IN;
	assign wr_blk = reg_wr_i && reg_addr_i == `AES_OFS_BLOCK_IN;
	assign wr_xor = reg_wr_i && reg_addr_i == `AES_OFS_XOR_IN;
	assign rd_res = reg_rd_i && reg_addr_i == `AES_OFS_RESULT;

	logic in_xor;
	logic [1:0] osel;
	assign in_xor = dcfg_q[`AES_DP_IN_XOR_BIT];
	assign osel = dcfg_q[`AES_DP_OSEL_MSB:`AES_DP_OSEL_LSB];

	// ----------------------------------------
	// key length and fold
	// ----------------------------------------
	logic [5:0] klen, ext, olen, last_idx;
	assign klen = (ksize_q == `AES_KSIZE_192) ? `AES_KLEN_192 :
		(ksize_q == `AES_KSIZE_256) ? `AES_KLEN_256 : `AES_KLEN_128;
	assign ext = klen - `AES_KLEN_128;
	assign olen = (osel == `AES_OSEL_KEY) ? klen : `AES_BLOCK_BYTES;
	assign last_idx = olen - 6'h1;

	logic [127:0] kfold, kext;
	// unused key bytes drop out of the fold
	assign kext = (ksize_q == `AES_KSIZE_256) ? key_q[255:128] :
		(ksize_q == `AES_KSIZE_192) ? {64'h0, key_q[191:128]} : 128'h0;
	assign kfold = key_q[127:0] ^ kext;
	// key output inverts only the low 16 key bytes; the extra key bytes pass unchanged
	logic [255:0] kout;
	assign kout = {key_q[255:128], key_q[127:0] ^ `AES_KINV_MASK};

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	// key size, direction, enable
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			ksize_q <= `AES_KSIZE_128;
			enc_q <= 1'b0;
			en_q <= 1'b0;
			dma_q <= 1'b0;
		end else if (wr_cfg) begin
			ksize_q <= reg_wdata_i[`AES_CFG_KSIZE_MSB:`AES_CFG_KSIZE_LSB];
			enc_q <= reg_wdata_i[`AES_CFG_ENC_BIT];
			en_q <= reg_wdata_i[`AES_CFG_EN_BIT];
			dma_q <= reg_wdata_i[`AES_CFG_DMA_BIT];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			dcfg_q <= `AES_DP_RESET;
		end else if (wr_dcfg) begin
			dcfg_q <= reg_wdata_i[2:0];
		end
	end

	logic core_fin;
	// a disabled block aborts, so no completion while enable is low
	assign core_fin = st_q == ST_BUSY && cnt_q == 16'h0 && en_q;

	// done on completion, set wins over clear
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			done_q <= 1'b0;
		end else if (core_fin) begin
			done_q <= 1'b1;
		end else if (!en_q ||
			(wr_cfg && !reg_wdata_i[`AES_CFG_DONE_BIT])) begin
			done_q <= 1'b0;
		end
	end

	// block and xor byte latches
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			blk_q <= 8'h0;
			xor_q <= 8'h0;
		end else begin
			if (wr_blk) begin
				blk_q <= reg_wdata_i;
			end
			if (wr_xor) begin
				xor_q <= reg_wdata_i;
			end
		end
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			st_q <= ST_OFF;
			idx_q <= 6'h0;
			cnt_q <= 16'h0;
		end else if (!en_q) begin
			st_q <= ST_OFF;
			idx_q <= 6'h0;
		end else begin
			case (st_q)
				ST_OFF: begin
					st_q <= ST_LOAD;
					idx_q <= 6'h0;
				end
				ST_LOAD: begin
					if (wr_key) begin
						idx_q <= idx_q + 6'h1;
						if (idx_q == `AES_BLOCK_BYTES - 6'h1) begin
							// extra key bytes after the block
							st_q <= (ext == 6'h0) ? ST_BUSY : ST_KEYX;
							cnt_q <= 16'(CORE_CYCLES - 1);
						end
					end
				end
				ST_KEYX: begin
					if (wr_key) begin
						idx_q <= idx_q + 6'h1;
						if (idx_q == klen - 6'h1) begin
							st_q <= ST_BUSY;
						end
					end
				end
				ST_BUSY: begin
					if (cnt_q == 16'h0) begin
						st_q <= ST_OUT;
						idx_q <= 6'h0;
					end else begin
						cnt_q <= cnt_q - 16'h1;
					end
				end
				ST_OUT: begin
					if (rd_res) begin
						idx_q <= idx_q + 6'h1;
						if (idx_q == last_idx) begin
							st_q <= ST_LOAD;
							idx_q <= 6'h0;
						end
					end
				end
				default: st_q <= ST_OFF;
			endcase
		end
	end

	// round phase: block, optional xor, key
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i || !en_q) begin
			ph_q <= 2'h0;
		end else if (st_q == ST_LOAD && wr_blk) begin
			ph_q <= in_xor ? 2'h1 : 2'h2;
		end else if (st_q == ST_LOAD && wr_xor) begin
			ph_q <= 2'h2;
		end else if (st_q == ST_OUT && wr_xor) begin
			ph_q <= 2'h1;
		end else if ((st_q == ST_LOAD && wr_key) ||
			(st_q == ST_OUT && rd_res) ||
			(st_q != ST_LOAD && st_q != ST_OUT)) begin
			ph_q <= 2'h0;
		end
	end

	// input mux into the data block
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			data_q <= 128'h0;
		end else if (st_q == ST_LOAD && wr_key) begin
			data_q[idx_q[3:0]*8 +: 8] <= in_xor ? blk_q ^ xor_q : blk_q;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			key_q <= 256'h0;
		end else if ((st_q == ST_LOAD || st_q == ST_KEYX) && wr_key) begin
			key_q[idx_q[4:0]*8 +: 8] <= reg_wdata_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			res_q <= 128'h0;
		end else if (core_fin) begin
			res_q <= enc_q ? data_q ^ kfold : data_q ^ kfold ^ `AES_KINV_MASK;
		end
	end

	// ----------------------------------------
	// output mux
	// ----------------------------------------
	logic [5:0] kidx;
	logic [7:0] out_byte;
	assign kidx = (idx_q < ext) ? idx_q + `AES_KLEN_128 : idx_q - ext;

	always_comb begin
		case (osel)
			`AES_OSEL_DATA_XOR: out_byte = res_q[idx_q[3:0]*8 +: 8] ^ xor_q;
			`AES_OSEL_KEY: out_byte = kout[kidx[4:0]*8 +: 8];
			default: out_byte = res_q[idx_q[3:0]*8 +: 8];
		endcase
	end

	// ----------------------------------------
	// register read
	// ----------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i || !reg_rd_i) begin
			rdata_q <= 8'h0;
		end else begin
			case (reg_addr_i)
				`AES_OFS_CORE_CFG:
					rdata_q <= {2'h0, done_q, dma_q, en_q, enc_q, ksize_q};
				`AES_OFS_DP_CFG: rdata_q <= {5'h0, dcfg_q};
				`AES_OFS_RESULT: rdata_q <= (st_q == ST_OUT) ? out_byte : 8'h0;
				default: rdata_q <= 8'h0;
			endcase
		end
	end
	assign reg_rdata_o = rdata_q;

	// ----------------------------------------
	// dma requests
	// ----------------------------------------
	logic [2:0] tgt;
	logic acc;
	// inputs while loading; after completion results, each after its xor byte when the output is data xor
	always_comb begin
		tgt = `AES_OFS_KEY_IN;
		if (st_q == ST_LOAD && ph_q == 2'h0) begin
			tgt = `AES_OFS_BLOCK_IN;
		end else if (st_q == ST_LOAD && ph_q == 2'h1) begin
			tgt = `AES_OFS_XOR_IN;
		end else if (st_q == ST_OUT) begin
			tgt = (osel == `AES_OSEL_DATA_XOR && ph_q == 2'h0) ?
				`AES_OFS_XOR_IN : `AES_OFS_RESULT;
		end
	end
	assign acc = dreq_q.valid && reg_addr_i == dreq_q.addr &&
		(dreq_q.addr == `AES_OFS_RESULT ? reg_rd_i : reg_wr_i);

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			dreq_q <= '0;
		end else if (!en_q || !dma_q || acc) begin
			dreq_q <= '0;
		end else if (!dreq_q.valid && (st_q == ST_LOAD ||
			st_q == ST_KEYX || st_q == ST_OUT)) begin
			dreq_q.valid <= 1'b1;
			dreq_q.addr <= tgt;
		end
	end
	assign dma_req_o = dreq_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	done_set_a: assert property (core_fin |=> done_q && st_q == ST_OUT)
		else $error("done not set at block completion");
	done_hold_a: assert property (
		done_q && en_q && !wr_cfg |=> done_q)
		else $error("done dropped without a clear");
	disable_rst_a: assert property (
		!en_q |=> st_q == ST_OFF && !done_q && !dreq_q.valid)
		else $error("disable did not reset sequencer");
	busy_len_a: assert property (
		$rose(st_q == ST_BUSY) |-> idx_q == klen)
		else $error("core started before the whole block");
	load_count_a: assert property (
		st_q == ST_LOAD && en_q && wr_key |=> idx_q == $past(idx_q) + 6'h1)
		else $error("key write did not advance sequencer");
	ext_key_a: assert property (
		st_q == ST_LOAD && en_q && wr_key && idx_q == 6'hf && ext != 6'h0
		|=> st_q == ST_KEYX)
		else $error("extended key bytes not accepted");
	next_blk_a: assert property (
		st_q == ST_OUT && en_q && rd_res && idx_q == last_idx
		|=> st_q == ST_LOAD && idx_q == 6'h0)
		else $error("sequencer did not return for next block");
	req_gap_a: assert property (acc |=> !dreq_q.valid)
		else $error("request held after acceptance");
	key_order_a: assert property (
		st_q == ST_OUT && osel == `AES_OSEL_KEY && idx_q == 6'h0 &&
		ext != 6'h0 |-> kidx == `AES_KLEN_128)
		else $error("extended key bytes not first");
	dma_in_a: assert property (
		dreq_q.valid && st_q == ST_LOAD |-> dreq_q.addr != `AES_OFS_RESULT)
		else $error("result requested while loading");
endmodule

/* File: verification/aes_dma_model.sv */
`timescale 1ns/1ps
`include "aes_defines.svh"

module aes_dma_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clr_i,
	input wire logic slow_i,
	input aes_pkg::aes_dma_req_t req_i,
	input wire logic [7:0] rdata_i,
	output logic [2:0] addr_o = 3'h0,
	output logic [7:0] wdata_o = 8'h0,
	output logic wr_o = 1'h0,
	output logic rd_o = 1'h0
);
	import aes_pkg::*;
	logic [7:0] key_m [32];
	logic [7:0] blk_m [32];
	logic [7:0] got_m [32];
	int kn, bn, gn, wt;
	logic [1:0] st;
	logic cap;
	logic go;

	// block channel holds two blocks, then runs dry
	assign go = req_i.valid &&
		(req_i.addr != `AES_OFS_BLOCK_IN || bn < 32);

	always @(posedge clk_i) begin
		cap <= rd_o;
		if (cap && gn < 32) begin
			got_m[gn] <= rdata_i;
			gn <= gn + 1;
		end
		if (rst_i || clr_i) begin
			st <= 2'h0;
			wr_o <= 1'h0;
			rd_o <= 1'h0;
			cap <= 1'h0;
			kn <= 0;
			bn <= 0;
			gn <= 0;
			wt <= 0;
		end else case (st)
		2'h0: if (go && slow_i && wt < 3) begin
			wt <= wt + 1;
		end else if (go) begin
			wt <= 0;
			st <= 2'h1;
			addr_o <= req_i.addr;
			case (req_i.addr)
			`AES_OFS_KEY_IN: begin
				wdata_o <= key_m[kn % 16];
				kn <= kn + 1;
				wr_o <= 1'h1;
			end
			`AES_OFS_BLOCK_IN: begin
				wdata_o <= blk_m[bn];
				bn <= bn + 1;
				wr_o <= 1'h1;
			end
			default: rd_o <= 1'h1;
			endcase
		end
		2'h1: begin
			wr_o <= 1'h0;
			rd_o <= 1'h0;
			wdata_o <= ~wdata_o;
			st <= 2'h2;
		end
		default: if (!req_i.valid) begin
			st <= 2'h0;
		end
		endcase
	end
endmodule

/* File: verification/tb.sv */
`timescale 1ns/1ps
`include "aes_defines.svh"

module tb;
	import aes_pkg::*;
	logic clk_sys_i = 1'h0;
	logic sys_rst_i = 1'h1;
	logic [2:0] t_addr = 3'h0;
	logic [7:0] t_wd = 8'h0;
	logic t_wr = 1'h0;
	logic t_rd = 1'h0;
	logic m_clr = 1'h0;
	logic m_slow = 1'h0;
	logic [2:0] m_addr;
	logic [7:0] m_wd;
	logic m_wr;
	logic m_rd;
	logic m_act;
	logic [7:0] rdata;
	aes_dma_req_t dreq;
	logic [7:0] p [16];
	logic [7:0] x [16];
	logic [7:0] k [32];
	int err_count = 0;
	int checks = 0;

	assign m_act = m_wr | m_rd;
	always #2.5 clk_sys_i = ~clk_sys_i;

	aes_block_cipher #(.CORE_CYCLES(2)) uut (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.reg_addr_i(m_act ? m_addr : t_addr),
		.reg_wdata_i(m_act ? m_wd : t_wd),
		.reg_wr_i(t_wr | m_wr),
		.reg_rd_i(t_rd | m_rd),
		.reg_rdata_o(rdata),
		.dma_req_o(dreq)
	);

	aes_dma_model dma (
		.clk_i(clk_sys_i),
		.rst_i(sys_rst_i),
		.clr_i(m_clr),
		.slow_i(m_slow),
		.req_i(dreq),
		.rdata_i(rdata),
		.addr_o(m_addr),
		.wdata_o(m_wd),
		.wr_o(m_wr),
		.rd_o(m_rd)
	);

	// ----------------------------------------
	// bus access and checking
	// ----------------------------------------
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		t_addr <= a;
		t_wd <= d;
		t_wr <= 1'h1;
		@(posedge clk_sys_i);
		t_wr <= 1'h0;
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		t_addr <= a;
		t_rd <= 1'h1;
		@(posedge clk_sys_i);
		t_rd <= 1'h0;
		@(negedge clk_sys_i);
		d = rdata;
	endtask

	task automatic chk(input string n, input logic [7:0] s,
		input logic [7:0] e);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("unexpected %s exp %h got %h", n, e, s);
		end
	endtask

	task automatic rdc(input string n, input logic [2:0] a,
		input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		chk(n, v, e);
	endtask

	function automatic logic [7:0] ex(input int i, input int kl,
		input bit enc, input logic [7:0] d);
		logic [7:0] f;
		f = k[i];
		if (i < kl - 16) f = f ^ k[16 + i];
		return enc ? d ^ f : d ^ f ^ 8'h63;
	endfunction

	task automatic load(input int kl, input bit ix);
		for (int i = 0; i < 16; i++) begin
			wr(`AES_OFS_BLOCK_IN, p[i]);
			if (ix) wr(`AES_OFS_XOR_IN, x[i]);
			wr(`AES_OFS_KEY_IN, k[i]);
			if (i == 8) rdc("early_out", `AES_OFS_RESULT, 8'h00);
		end
		for (int i = 16; i < kl; i++) wr(`AES_OFS_KEY_IN, k[i]);
	endtask

	task automatic wait_done(input logic [7:0] cfg);
		logic [7:0] v;
		for (int n = 0; n < 50; n++) begin
			rd(`AES_OFS_CORE_CFG, v);
			if (v[5] === 1'h1) break;
		end
		chk("core_cfg", v, cfg | 8'h20);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic s_reset();
		rdc("core_cfg", `AES_OFS_CORE_CFG, 8'h00);
		rdc("dp_cfg", `AES_OFS_DP_CFG, 8'h00);
		wr(3'h7, 8'hff);
		rdc("unmapped", 3'h7, 8'h00);
		rdc("idle_out", `AES_OFS_RESULT, 8'h00);
	endtask

	task automatic s_cipher(input int kl, input bit enc,
		input logic [2:0] dp);
		logic [7:0] v;
		logic [7:0] d;
		logic [7:0] cfg;
		cfg = 8'(8'h08 | (enc << 2) | (kl - 16) / 8);
		wr(`AES_OFS_DP_CFG, {5'h0, dp});
		wr(`AES_OFS_CORE_CFG, cfg);
		rdc("dp_cfg", `AES_OFS_DP_CFG, {5'h0, dp});
		load(kl, dp[0]);
		wait_done(cfg);
		for (int i = 0; i < 16; i++) begin
			d = dp[0] ? p[i] ^ x[i] : p[i];
			if (dp[2:1] == 2'h1) wr(`AES_OFS_XOR_IN, x[i]);
			rd(`AES_OFS_RESULT, v);
			if (dp[2:1] == 2'h1) d = d ^ x[i];
			chk("result", v, ex(i, kl, enc, d));
		end
	endtask

	task automatic s_keyinv(input int kl);
		logic [7:0] v;
		logic [7:0] cfg;
		int idx;
		cfg = 8'(8'h0c | (kl - 16) / 8);
		wr(`AES_OFS_DP_CFG, 8'h04);
		wr(`AES_OFS_CORE_CFG, cfg);
		load(kl, 1'b0);
		wait_done(cfg);
		for (int j = 0; j < kl; j++) begin
			idx = j < kl - 16 ? 16 + j : j - (kl - 16);
			rd(`AES_OFS_RESULT, v);
			chk("key_out", v, idx < 16 ? k[idx] ^ 8'h63 : k[idx]);
		end
		rdc("done_kept", `AES_OFS_CORE_CFG, cfg | 8'h20);
		wr(`AES_OFS_CORE_CFG, cfg);
		rdc("done_clr", `AES_OFS_CORE_CFG, cfg);
	endtask

	task automatic s_abort();
		wr(`AES_OFS_CORE_CFG, 8'h00);
		rdc("disabled", `AES_OFS_CORE_CFG, 8'h00);
		wr(`AES_OFS_DP_CFG, 8'h00);
		wr(`AES_OFS_CORE_CFG, 8'h0c);
		for (int i = 0; i < 5; i++) begin
			wr(`AES_OFS_BLOCK_IN, 8'ha5);
			wr(`AES_OFS_KEY_IN, 8'h3c);
		end
		wr(`AES_OFS_CORE_CFG, 8'h00);
		s_cipher(16, 1'b1, 3'h0);
	endtask

	task automatic s_dma(input bit slow);
		wr(`AES_OFS_CORE_CFG, 8'h00);
		m_clr <= 1'h1;
		m_slow <= slow;
		@(posedge clk_sys_i);
		m_clr <= 1'h0;
		for (int i = 0; i < 32; i++) begin
			dma.key_m[i] = k[i % 16];
			dma.blk_m[i] = i < 16 ? p[i] : p[i - 16] ^ 8'h5a;
		end
		wr(`AES_OFS_DP_CFG, 8'h00);
		wr(`AES_OFS_CORE_CFG, 8'h1c);
		for (int n = 0; n < 6000 && dma.gn < 32; n++) @(posedge clk_sys_i);
		repeat (20) @(posedge clk_sys_i);
		chk("dma_reads", 8'(dma.gn), 8'h20);
		chk("dma_keys", 8'(dma.kn), 8'h20);
		for (int i = 0; i < 32; i++)
			chk("dma_out", dma.got_m[i], ex(i % 16, 16, 1'b1,
				dma.blk_m[i]));
		wr(`AES_OFS_CORE_CFG, 8'h00);
	endtask

	// ----------------------------------------
	// run control
	// ----------------------------------------
	task automatic complete_run();
		$display("errors %0d checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		#100000;
		err_count++;
		complete_run();
	end

	initial begin
		for (int i = 0; i < 32; i++) k[i] = 8'(i * 29 + 7);
		for (int i = 0; i < 16; i++) begin
			p[i] = 8'(i * 13 + 1);
			x[i] = 8'(i * 7 + 90);
		end
		repeat (6) @(posedge clk_sys_i);
		sys_rst_i <= 1'h0;
		s_reset();
		for (int ks = 0; ks < 3; ks++)
			for (int e = 0; e < 2; e++)
				s_cipher(16 + 8 * ks, e[0], 3'({ks == 1, e[0]}));
		s_abort();
		for (int ks = 0; ks < 3; ks++) s_keyinv(16 + 8 * ks);
		s_dma(1'b0);
		s_dma(1'b1);
		complete_run();
	end
endmodule
